//--- dmc_die_monitor_cam_switch.sv
// Die monitor channels and cam limit switch channels synchronised to crank angle
`timescale 1ns/1ps
`default_nettype none

module dmc_die_monitor_cam_switch #(
   parameter int MS_CYCLES = dmc_pkg::MS_CYCLES
) (
   input  wire logic                                         ref_clk,
   input  wire logic                                         rst,
   input  wire logic [dmc_pkg::ANG_W-1:0]                    crank_angle,
   input  wire logic [dmc_pkg::NUM_DM-1:0]                   dm_sensor,
   input  wire dmc_pkg::dmc_dm_cfg_s [dmc_pkg::NUM_DM-1:0]   dm_cfg,
   input  wire dmc_pkg::dmc_cam_cfg_s [dmc_pkg::NUM_CAM-1:0] cam_cfg,
   input  wire logic                                         fault_reset,
   input  wire logic                                         resume_op,
   output var dmc_pkg::dmc_status_s                          dm_status,
   output logic [dmc_pkg::NUM_POINTS-1:0]                    output_points
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      dmc_pkg::dmc_dm_ch_s [dmc_pkg::NUM_DM-1:0]        dm;
      logic [dmc_pkg::NUM_CAM-1:0]                      cam_win;
      logic [dmc_pkg::NUM_CAM-1:0]                      cam_out;
      logic [dmc_pkg::NUM_CAM-1:0][dmc_pkg::TIME_W-1:0] cam_cnt;
      logic [dmc_pkg::DIV_W-1:0]                        ms_div;
      logic [dmc_pkg::ANG_W-1:0]                        angle_prev;
      dmc_pkg::dmc_status_s                             status;
   } dmc_state_s;

   dmc_state_s state_q;
   dmc_state_s state_d;

   // ---------------------------------------------------------------
   // Local constants
   // ---------------------------------------------------------------
   // Severity ranks; a larger rank wins when channels fault together
   localparam logic [1:0]                 SEV_NONE  = 2'h0;
   localparam logic [1:0]                 SEV_ALARM = 2'h1;
   localparam logic [1:0]                 SEV_TOP   = 2'h2;
   localparam logic [1:0]                 SEV_NOW   = 2'h3;
   // One count per step; the prescaler restarts from zero
   localparam logic [dmc_pkg::TIME_W-1:0] CNT_STEP  = 16'h0001;
   localparam logic [dmc_pkg::DIV_W-1:0]  DIV_STEP  = 17'h0_0001;

   // On angle inclusive, off angle exclusive; on above off wraps past zero
   function automatic logic in_window(input logic [dmc_pkg::ANG_W-1:0] ang,
                                      input logic [dmc_pkg::ANG_W-1:0] on_a,
                                      input logic [dmc_pkg::ANG_W-1:0] off_a);
      logic r;
      if (on_a <= off_a) begin
         r = (ang >= on_a) && (ang < off_a);
      end else begin
         r = (ang >= on_a) || (ang < off_a);
      end
      return r;
   endfunction

   function automatic logic [1:0] severity(input dmc_pkg::dmc_resp_e r);
      logic [1:0] s;
      case (r)
         dmc_pkg::HALT_IMMEDIATE_RESPONSE: s = SEV_NOW;
         dmc_pkg::HALT_AT_TOP_RESPONSE:    s = SEV_TOP;
         dmc_pkg::ALARM_ONLY_RESPONSE:     s = SEV_ALARM;
         default:                          s = SEV_NONE;
      endcase
      return s;
   endfunction

   // Edges of a level against its value one clock earlier
   function automatic logic went_high(input logic cur, input logic prv);
      return cur & ~prv;
   endfunction

   function automatic logic went_low(input logic cur, input logic prv);
      return ~cur & prv;
   endfunction

   // ---------------------------------------------------------------
   // Angle windows
   // ---------------------------------------------------------------
   logic [dmc_pkg::NUM_DM-1:0]  dm_win;
   logic [dmc_pkg::NUM_CAM-1:0] cam_hit;

   // Windows evaluated once per edge and shared by the next-state logic
   for (genvar g = 0; g < dmc_pkg::NUM_DM; g++) begin : g_dm_win
      assign dm_win[g] = in_window(crank_angle, dm_cfg[g].on_angle, dm_cfg[g].off_angle);
   end

   always_comb begin
      cam_hit = '0;
      for (int c = 0; c < dmc_pkg::NUM_CAM; c++) begin
         for (int p = 0; p < dmc_pkg::NUM_PAIRS; p++) begin
            if (cam_cfg[c].pair_en[p] &&
                in_window(crank_angle, cam_cfg[c].on_angle[p], cam_cfg[c].off_angle[p])) begin
               cam_hit[c] = 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic                     stroke_top;
      logic                     ms_tick;
      logic                     win;
      logic                     sen;
      logic                     win_rise;
      logic                     win_fall;
      logic                     sen_rise;
      logic                     set;
      logic                     first;
      logic                     any;
      logic                     restored;
      logic [1:0]               worst;
      dmc_pkg::dmc_fault_e      kind;
      int                       pi;
      state_d    = state_q;
      stroke_top = 1'b0;
      ms_tick    = 1'b0;
      win        = 1'b0;
      sen        = 1'b0;
      win_rise   = 1'b0;
      win_fall   = 1'b0;
      sen_rise   = 1'b0;
      set        = 1'b0;
      first      = 1'b0;
      any        = 1'b0;
      restored   = 1'b0;
      worst      = SEV_NONE;
      kind       = dmc_pkg::FK_NONE;
      pi         = 0;

      state_d.angle_prev = crank_angle;
      // A crank run backwards would fake a stroke top on every step except the one through zero
      stroke_top         = crank_angle < state_q.angle_prev;

      // Free running prescaler: timed cam outputs are up to one ms early
      ms_tick = state_q.ms_div == dmc_pkg::DIV_W'(MS_CYCLES - 1);
      if (ms_tick) begin
         state_d.ms_div = '0;
      end else begin
         state_d.ms_div = state_q.ms_div + DIV_STEP;
      end

      // ------------------------------------------------------------
      // Die monitor channels
      // ------------------------------------------------------------
      for (int i = 0; i < dmc_pkg::NUM_DM; i++) begin
         pi       = (i == 0) ? 0 : i - 1;
         win      = dm_win[i];
         sen      = dm_sensor[i];
         win_rise = went_high(win, state_q.dm[i].in_win);
         win_fall = went_low(win, state_q.dm[i].in_win);
         sen_rise = went_high(sen, state_q.dm[i].sens);
         set      = 1'b0;
         kind     = dmc_pkg::FK_NONE;
         restored = 1'b1;
         case (dm_cfg[i].mode)
            dmc_pkg::PULSE_IN_WINDOW_MODE: begin
               if (win_rise && state_q.dm[i].armed && !state_q.dm[i].seen_on) begin
                  set  = 1'b1;
                  kind = dmc_pkg::FK_MISSING;
               end
               if (win_fall && sen) begin
                  set  = 1'b1;
                  kind = dmc_pkg::FK_STAYED_ON;
               end
               if (sen_rise && !win) begin
                  set  = 1'b1;
                  kind = dmc_pkg::FK_ON_OUTSIDE;
               end
               // A clean in-window pulse raises none of the above
               if (win_rise) begin
                  state_d.dm[i].seen_on = sen_rise;
               end else if (sen_rise) begin
                  state_d.dm[i].seen_on = 1'b1;
               end
            end
            dmc_pkg::IN_POSITION_MODE: begin
               if (win_rise && state_q.dm[i].armed && !state_q.dm[i].off_seen) begin
                  set  = 1'b1;
                  kind = dmc_pkg::FK_NO_RELEASE;
               end
               if (win && !sen) begin
                  set  = 1'b1;
                  kind = dmc_pkg::FK_DROPPED;
               end
               if (win_rise) begin
                  state_d.dm[i].off_seen = 1'b0;
               end else if (!win && !sen) begin
                  state_d.dm[i].off_seen = 1'b1;
               end
            end
            dmc_pkg::STATION_HANDOFF_MODE: begin
               // Entry station only records; it has no upstream partner
               first = (i == 0) || (dm_cfg[pi].mode != dmc_pkg::STATION_HANDOFF_MODE);
               if (win_rise) begin
                  state_d.dm[i].part = sen;
                  if (!first && state_q.dm[i].armed && (sen != state_q.dm[pi].held)) begin
                     set  = 1'b1;
                     kind = dmc_pkg::FK_MISMATCH;
                  end
               end
               // Shift register step once per stroke
               if (stroke_top) begin
                  state_d.dm[i].held = state_q.dm[i].part;
               end
               // Resume also wins over a shift on the same edge
               if (resume_op) begin
                  state_d.dm[i].part = sen;
                  state_d.dm[i].held = sen;
               end
            end
            dmc_pkg::STROKE_INDEPENDENT_MODE: begin
               restored = sen;
               if (!sen) begin
                  set  = 1'b1;
                  kind = dmc_pkg::FK_STATIC_OFF;
               end
            end
            default: begin
               set = 1'b0;
            end
         endcase
         if (dm_cfg[i].resp == dmc_pkg::NO_ACTION_RESPONSE) begin
            set = 1'b0;
         end
         if (win_rise) begin
            state_d.dm[i].armed = 1'b1;
         end
         // Set wins over reset in the same cycle
         if (fault_reset && restored) begin
            state_d.dm[i].fault = 1'b0;
            state_d.dm[i].kind  = dmc_pkg::FK_NONE;
         end
         if (set) begin
            state_d.dm[i].fault = 1'b1;
            state_d.dm[i].kind  = kind;
         end
         state_d.dm[i].in_win = win;
         state_d.dm[i].sens   = sen;
      end

      // ------------------------------------------------------------
      // Status: lowest numbered fault shown, strongest action driven
      // ------------------------------------------------------------
      state_d.status       = '0;
      state_d.status.kind  = dmc_pkg::FK_NONE;
      for (int i = dmc_pkg::NUM_DM - 1; i >= 0; i--) begin
         if (state_d.dm[i].fault) begin
            state_d.status.valid = 1'b1;
            state_d.status.chan  = dmc_pkg::CHAN_W'(i + 1);
            state_d.status.kind  = state_d.dm[i].kind;
            if (severity(dm_cfg[i].resp) > worst) begin
               worst = severity(dm_cfg[i].resp);
            end
         end
      end
      // No-action channels rank lowest, so they never drive an action
      state_d.status.halt_now  = worst == SEV_NOW;
      state_d.status.halt_top  = worst == SEV_TOP;
      state_d.status.alarm     = worst == SEV_ALARM;
      state_d.status.all_clear = !state_d.status.valid;

      // ------------------------------------------------------------
      // Cam limit switch channels
      // ------------------------------------------------------------
      for (int c = 0; c < dmc_pkg::NUM_CAM; c++) begin
         any = cam_hit[c];
         state_d.cam_win[c] = any;
         if (cam_cfg[c].timed) begin
            // Window entry restarts the timer even while the point is still on
            if (went_high(any, state_q.cam_win[c])) begin
               state_d.cam_out[c] = 1'b1;
               state_d.cam_cnt[c] = cam_cfg[c].time_ms;
            end else if (state_q.cam_out[c] && ms_tick) begin
               if (state_q.cam_cnt[c] <= CNT_STEP) begin
                  state_d.cam_out[c] = 1'b0;
                  state_d.cam_cnt[c] = '0;
               end else begin
                  state_d.cam_cnt[c] = state_q.cam_cnt[c] - CNT_STEP;
               end
            end
         end else begin
            state_d.cam_out[c] = any;
            state_d.cam_cnt[c] = '0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign dm_status = state_q.status;

   always_comb begin
      output_points = '0;
      for (int c = 0; c < dmc_pkg::NUM_CAM; c++) begin
         output_points[dmc_pkg::CAM_POINT_BASE + c] = state_q.cam_out[c];
      end
   end

endmodule
`default_nettype wire

//--- dmc_die_monitor_cam_switch_bench.sv
// Self-checking bench for the die monitor and cam switch block
`timescale 1ns/1ps
`default_nettype none
module dmc_die_monitor_cam_switch_bench;
   logic                                         ref_clk = 1'b0;
   logic                                         rst = 1'b1;
   logic                                         fault_reset = 1'b0;
   logic                                         resume_op = 1'b0;
   logic [1:0]                                   sens_lo = 2'h2;
   logic [13:0]                                  sens_hi = 14'h0000;
   logic [15:0]                                  lfsr = 16'h998c;
   wire logic [dmc_pkg::ANG_W-1:0]               crank_angle;
   wire logic [dmc_pkg::NUM_DM-1:0]              dm_sensor;
   dmc_pkg::dmc_dm_cfg_s [dmc_pkg::NUM_DM-1:0]   dm_cfg;
   dmc_pkg::dmc_cam_cfg_s [dmc_pkg::NUM_CAM-1:0] cam_cfg;
   dmc_pkg::dmc_status_s                         dm_status;
   logic [dmc_pkg::NUM_POINTS-1:0]               output_points;
   logic [28:0]                                  exp_q[$];
   logic [28:0]                                  exp_v;
   int                                           n_mismatch = 0;
   int                                           checks_done = 0;
   event                                         chk_ev;
   assign dm_sensor = {sens_hi, sens_lo};
   always #5 ref_clk = ~ref_clk;
   dmc_press_model press_u (.ref_clk(ref_clk), .rst(rst), .crank_angle(crank_angle));
   dmc_die_monitor_cam_switch #(.MS_CYCLES(10)) dut_u (
      .ref_clk(ref_clk), .rst(rst), .crank_angle(crank_angle), .dm_sensor(dm_sensor),
      .dm_cfg(dm_cfg), .cam_cfg(cam_cfg), .fault_reset(fault_reset), .resume_op(resume_op),
      .dm_status(dm_status), .output_points(output_points));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic dmc_pkg::dmc_status_s st(input logic [4:0] c, input dmc_pkg::dmc_fault_e k,
                                               input int act);
      return '{c != 5'h00, c, k, act == 1, act == 2, act == 3, c == 5'h00};
   endfunction
   // Timed point is only judged clear of its early-tick uncertainty
   function automatic logic [15:0] pts(input int a);
      pts = 16'h0000;
      pts[8] = a >= 300 || a < 20;
      pts[15] = a >= 105 && a <= 140;
   endfunction
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wait_ang(input int a);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (crank_angle != a && n < 400);
      if (n >= 400) begin
         n_mismatch++;
         end_sim();
      end
   endtask
   task automatic chk_at(input int a, input dmc_pkg::dmc_status_s s);
      wait_ang(a);
      @(negedge ref_clk);
      exp_q.push_back({s, pts(a)});
      ->chk_ev;
   endtask
   task automatic clr(input int a);
      wait_ang(a);
      fault_reset <= 1'b1;
      @(posedge ref_clk);
      fault_reset <= 1'b0;
   endtask
   // ---------------------------------------------------------------
   // Noise on no-action channels and resume input
   // ---------------------------------------------------------------
   always @(posedge ref_clk) begin
      lfsr <= nxt(lfsr);
      sens_hi <= lfsr[13:0];
      resume_op <= lfsr[15] & lfsr[3];
   end
   always @(chk_ev) begin
      exp_v = exp_q.pop_front();
      checks_done++;
      if ({dm_status, output_points} !== exp_v) begin
         n_mismatch++;
         $display("BAD t=%0t got %h exp %h", $time, {dm_status, output_points}, exp_v);
      end
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      dm_cfg[0] = '{dmc_pkg::PULSE_IN_WINDOW_MODE, dmc_pkg::ALARM_ONLY_RESPONSE, 9'h050, 9'h06e};
      dm_cfg[1] = '{dmc_pkg::STROKE_INDEPENDENT_MODE, dmc_pkg::HALT_IMMEDIATE_RESPONSE,
                    9'h000, 9'h000};
      for (int i = 2; i < dmc_pkg::NUM_DM; i++) begin
         dm_cfg[i] = '{dmc_pkg::dmc_mode_e'(i[1:0]), dmc_pkg::NO_ACTION_RESPONSE,
                       9'h0c8, 9'h0fa};
      end
      cam_cfg = '0;
      cam_cfg[0].pair_en = 8'h08;
      cam_cfg[0].on_angle[3] = 9'h12c;
      cam_cfg[0].off_angle[3] = 9'h014;
      cam_cfg[7].pair_en = 8'h01;
      cam_cfg[7].on_angle[0] = 9'h064;
      cam_cfg[7].off_angle[0] = 9'h065;
      cam_cfg[7].timed = 1'b1;
      cam_cfg[7].time_ms = 16'h0005;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      chk_at(60, st(5'h00, dmc_pkg::FK_NONE, 0));
      wait_ang(90);
      sens_lo[0] <= 1'b1;
      wait_ang(95);
      sens_lo[0] <= 1'b0;
      chk_at(115, st(5'h00, dmc_pkg::FK_NONE, 0));
      chk_at(10, st(5'h00, dmc_pkg::FK_NONE, 0));
      wait_ang(105);
      sens_lo[0] <= 1'b1;
      chk_at(125, st(5'h01, dmc_pkg::FK_STAYED_ON, 1));
      sens_lo[0] <= 1'b0;
      clr(200);
      chk_at(210, st(5'h00, dmc_pkg::FK_NONE, 0));
      chk_at(90, st(5'h00, dmc_pkg::FK_NONE, 0));
      chk_at(90, st(5'h01, dmc_pkg::FK_MISSING, 1));
      wait_ang(120);
      sens_lo[1] <= 1'b0;
      chk_at(130, st(5'h01, dmc_pkg::FK_MISSING, 3));
      sens_lo[1] <= 1'b1;
      clr(200);
      chk_at(210, st(5'h00, dmc_pkg::FK_NONE, 0));
      wait_ang(50);
      sens_lo[0] <= 1'b1;
      chk_at(60, st(5'h01, dmc_pkg::FK_ON_OUTSIDE, 1));
      sens_lo[0] <= 1'b0;
      clr(65);
      chk_at(75, st(5'h00, dmc_pkg::FK_NONE, 0));
      @(negedge ref_clk);
      end_sim();
   end
endmodule
bind dmc_die_monitor_cam_switch dmc_monitor #(.MS_CYCLES(MS_CYCLES)) mon_u (
   .ref_clk(ref_clk), .rst(rst), .crank_angle(crank_angle), .dm_sensor(dm_sensor),
   .dm_cfg(dm_cfg), .cam_cfg(cam_cfg), .fault_reset(fault_reset), .resume_op(resume_op),
   .dm_status(dm_status), .output_points(output_points));
`default_nettype wire

//--- dmc_monitor.sv
// Port-level assertions for the die monitor and cam switch block
`timescale 1ns/1ps
`default_nettype none
module dmc_monitor #(
   parameter int MS_CYCLES = dmc_pkg::MS_CYCLES
) (
   input wire logic                                         ref_clk,
   input wire logic                                         rst,
   input wire logic [dmc_pkg::ANG_W-1:0]                    crank_angle,
   input wire logic [dmc_pkg::NUM_DM-1:0]                   dm_sensor,
   input wire dmc_pkg::dmc_dm_cfg_s [dmc_pkg::NUM_DM-1:0]   dm_cfg,
   input wire dmc_pkg::dmc_cam_cfg_s [dmc_pkg::NUM_CAM-1:0] cam_cfg,
   input wire logic                                         fault_reset,
   input wire logic                                         resume_op,
   input wire dmc_pkg::dmc_status_s                         dm_status,
   input wire logic [dmc_pkg::NUM_POINTS-1:0]               output_points
);
   logic static_low;
   logic cam0;
   logic win0;
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic inw(input logic [8:0] a, input logic [8:0] on, input logic [8:0] off);
      return (on < off && a >= on && a < off) || (on > off && (a >= on || a < off));
   endfunction
   always_comb begin
      static_low = 1'b0;
      cam0 = 1'b0;
      for (int i = 0; i < dmc_pkg::NUM_DM; i++) begin
         if (dm_cfg[i].mode == dmc_pkg::STROKE_INDEPENDENT_MODE && !dm_sensor[i]
             && dm_cfg[i].resp != dmc_pkg::NO_ACTION_RESPONSE) static_low = 1'b1;
      end
      for (int p = 0; p < dmc_pkg::NUM_PAIRS; p++) begin
         if (cam_cfg[0].pair_en[p] && inw(crank_angle, cam_cfg[0].on_angle[p],
             cam_cfg[0].off_angle[p])) cam0 = 1'b1;
      end
   end
   assign win0 = inw(crank_angle, dm_cfg[0].on_angle, dm_cfg[0].off_angle);
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   low_points_zero_a: assert property (output_points[7:0] == 8'h00)
      else $error("low output points driven");
   clear_flag_a: assert property (!$past(rst) |-> dm_status.all_clear == !dm_status.valid)
      else $error("all clear disagrees with fault flag");
   action_onehot_a: assert property ($onehot0({dm_status.alarm, dm_status.halt_top,
      dm_status.halt_now}) && (dm_status.valid || !dm_status.alarm && !dm_status.halt_top))
      else $error("fault actions not one hot");
   chan_range_a: assert property (dm_status.valid |-> dm_status.chan >= 5'h01
      && dm_status.chan <= 5'h10 && dm_status.kind != dmc_pkg::FK_NONE)
      else $error("fault report without channel or kind");
   static_off_a: assert property (static_low |-> ##[1:3] dm_status.valid)
      else $error("static input low without fault");
   fault_latch_a: assert property (dm_status.valid && !fault_reset && !$past(fault_reset)
      |=> dm_status.valid)
      else $error("fault dropped without reset");
   cam_follow_a: assert property (!$past(rst) && !cam_cfg[0].timed
      |-> output_points[8] == $past(cam0))
      else $error("cam point does not follow angle window");
   outside_on_a: assert property ($rose(dm_sensor[0]) && !win0
      && dm_cfg[0].mode == dmc_pkg::PULSE_IN_WINDOW_MODE
      && dm_cfg[0].resp != dmc_pkg::NO_ACTION_RESPONSE |-> ##[1:3] dm_status.valid)
      else $error("sensor on outside window without fault");
   reset_state_a: assert property (disable iff (1'b0) rst |=> !dm_status.valid
      && output_points == 16'h0000)
      else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

//--- dmc_pkg.sv
// Shared constants, enums and carrier structs for the die monitor and cam switch block
package dmc_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int NUM_DM         = 16;
   localparam int NUM_CAM        = 8;
   localparam int NUM_PAIRS      = 8;
   localparam int ANG_W          = 9;
   localparam int CHAN_W         = 5;
   localparam int TIME_W         = 16;
   localparam int DIV_W          = 17;
   localparam int NUM_POINTS     = 16;
   localparam int CAM_POINT_BASE = 8;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

   localparam logic [ANG_W-1:0] ANGLE_MAX = 9'h167;

   // ---------------------------------------------------------------
   // Modes, responses, fault kinds
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PULSE_IN_WINDOW_MODE     = 2'h0,
      IN_POSITION_MODE         = 2'h1,
      STATION_HANDOFF_MODE     = 2'h2,
      STROKE_INDEPENDENT_MODE  = 2'h3
   } dmc_mode_e;

   typedef enum logic [1:0] {
      NO_ACTION_RESPONSE       = 2'h0,
      ALARM_ONLY_RESPONSE      = 2'h1,
      HALT_AT_TOP_RESPONSE     = 2'h2,
      HALT_IMMEDIATE_RESPONSE  = 2'h3
   } dmc_resp_e;

   typedef enum logic [2:0] {
      FK_NONE       = 3'h0,
      FK_ON_OUTSIDE = 3'h1,
      FK_STAYED_ON  = 3'h2,
      FK_MISSING    = 3'h3,
      FK_DROPPED    = 3'h4,
      FK_NO_RELEASE = 3'h5,
      FK_MISMATCH   = 3'h6,
      FK_STATIC_OFF = 3'h7
   } dmc_fault_e;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      dmc_mode_e        mode;
      dmc_resp_e        resp;
      logic [ANG_W-1:0] on_angle;
      logic [ANG_W-1:0] off_angle;
   } dmc_dm_cfg_s;

   typedef struct packed {
      logic [NUM_PAIRS-1:0]              pair_en;
      logic [NUM_PAIRS-1:0][ANG_W-1:0]   on_angle;
      logic [NUM_PAIRS-1:0][ANG_W-1:0]   off_angle;
      logic                              timed;
      logic [TIME_W-1:0]                 time_ms;
   } dmc_cam_cfg_s;

   typedef struct packed {
      logic              valid;
      logic [CHAN_W-1:0] chan;
      dmc_fault_e        kind;
      logic              alarm;
      logic              halt_top;
      logic              halt_now;
      logic              all_clear;
   } dmc_status_s;

   typedef struct packed {
      logic       in_win;
      logic       sens;
      logic       armed;
      logic       seen_on;
      logic       off_seen;
      logic       part;
      logic       held;
      logic       fault;
      dmc_fault_e kind;
   } dmc_dm_ch_s;

endpackage

//--- dmc_press_model.sv
// Crank angle source standing in for the resolver side of the press
`timescale 1ns/1ps
`default_nettype none
module dmc_press_model (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   output var logic [dmc_pkg::ANG_W-1:0] crank_angle
);
   // One degree a clock keeps a stroke at 360 cycles
   initial crank_angle = 9'h000;
   always @(posedge ref_clk) begin
      if (rst || crank_angle == dmc_pkg::ANGLE_MAX) crank_angle <= 9'h000;
      else crank_angle <= crank_angle + 9'h001;
   end
endmodule
`default_nettype wire
